// ### core/mram_port_consts.svh
// constants for the clocked memory host port: widths, timing counts and depths
`ifndef MRAM_PORT_CONSTS_SVH
`define MRAM_PORT_CONSTS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define MRAM_ADDR_W 20
`define MRAM_DATA_W 16
`define MRAM_BYTE_W 8
`define MRAM_PTR_W 21

// ----------------------------------------------------------------------------
// timing at the 200 MHz core clock
// ----------------------------------------------------------------------------
`define MRAM_CLK_PERIOD_NS 5
`define MRAM_SENSE_NS 50
// least time: round up
`define MRAM_SENSE_CYC ((`MRAM_SENSE_NS + `MRAM_CLK_PERIOD_NS - 1) / `MRAM_CLK_PERIOD_NS)
`define MRAM_CARRY_NS 10
// longest time: round down, with no floor at one cycle
`define MRAM_CARRY_CYC (`MRAM_CARRY_NS / `MRAM_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// buffering and stepping
// ----------------------------------------------------------------------------
`define MRAM_FIFO_DEPTH 32
`define MRAM_STEP_WORD 2
`define MRAM_STEP_BYTE 1

`endif

// ### core/mram_port_pkg.sv
// types of the memory host port: cycle kinds and the entries of its write buffer
`include "mram_port_consts.svh"

package mram_port_pkg;

  // --------------------------------------------------------------------------
  // cycle kinds decoded at each bus clock rising edge
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_DISABLE,
    CYC_READ,
    CYC_WRITE,
    CYC_AUTO_READ
  } cycle_t;

  // --------------------------------------------------------------------------
  // one buffered write: word address, byte lane, width mode and data
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`MRAM_ADDR_W-1:0] word_addr;
    logic lane;
    logic narrow;
    logic [`MRAM_DATA_W-1:0] data;
  } write_req_t;

endpackage : mram_port_pkg

// ### core/sync_mram_host_port.sv
// clocked host port of a nonvolatile memory: cycle decode, sensing, buffered writes
// How it works
// - select low, write low, no burst: read
// - select low, write high, no burst: write
// - select high without burst: cycle disabled
// - select low, burst with begin, no finish, carry: auto read
// - burst with begin low: cycle disabled
// - burst with finish high: cycle disabled
// - burst with carry input low: disabled
// - read drives when clock and enable high
// - read tristates when enable low
// - read tristates while bus clock low
// - write and disable cycles never drive
// - auto read drives while select low
// - auto read tristates while select high
// - read waits for sensing to finish
// - carry output rises on pointer overflow
`include "mram_port_consts.svh"

// ----------------------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------------------
module mram_write_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = `MRAM_FIFO_DEPTH
) (
  // clock, reset and freeze
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // handshakes are combinational so the source sees back-pressure at once
  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_ptr_reg];

  // storage has no reset; only pointers and fill level carry control state
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : mram_write_fifo

// ----------------------------------------------------------------------------
// host port
// ----------------------------------------------------------------------------
module sync_mram_host_port #(
  parameter int SENSE_CYC = `MRAM_SENSE_CYC,
  parameter int FIFO_DEPTH = `MRAM_FIFO_DEPTH
) (
  // core clock, reset and freeze
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // bus clock and controls, synchronous to i_mclk
  input wire logic i_bus_clk,
  input wire logic i_chip_sel_n,
  input wire logic i_write_sel,
  input wire logic i_out_drive_en,
  input wire logic i_burst_step_mode,
  input wire logic i_seq_begin,
  input wire logic i_seq_finish,
  input wire logic i_carry_in,
  input wire logic i_byte_width_select,
  // address and data
  input wire logic [`MRAM_ADDR_W-1:0] i_addr,
  input wire logic i_addr_lsb,
  input wire logic [`MRAM_DATA_W-1:0] i_dq,
  output logic [`MRAM_DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  // status
  output logic o_carry_out,
  output logic o_write_ready
);
  localparam int SW = $clog2(SENSE_CYC + 1);
  localparam int RW = $bits(mram_port_pkg::write_req_t);

  logic [`MRAM_BYTE_W-1:0] mem_lo [2**`MRAM_ADDR_W];
  logic [`MRAM_BYTE_W-1:0] mem_hi [2**`MRAM_ADDR_W];
  mram_port_pkg::cycle_t mode_reg;
  mram_port_pkg::cycle_t cyc_next;
  logic bus_clk_reg;
  logic bus_edge;
  logic [SW-1:0] sense_cnt_reg;
  logic sense_done_reg;
  logic [`MRAM_PTR_W-1:0] ptr_reg;
  logic [`MRAM_PTR_W-1:0] read_ptr_reg;
  logic read_narrow_reg;
  logic [`MRAM_DATA_W-1:0] dq_reg;
  logic carry_reg;
  logic [`MRAM_PTR_W:0] ptr_sum;
  mram_port_pkg::write_req_t push_req;
  mram_port_pkg::write_req_t pop_req;
  logic push_valid;
  logic pop_valid;
  logic pop_ready;

  // decode the control pins into one cycle kind
  function automatic mram_port_pkg::cycle_t decode_cycle(
    input logic cs_n, input logic we, input logic burst,
    input logic beg, input logic fin, input logic cin
  );
    mram_port_pkg::cycle_t k;
    if (burst && (!beg || fin || !cin)) begin
      k = mram_port_pkg::CYC_DISABLE;
    end else if (cs_n) begin
      k = mram_port_pkg::CYC_DISABLE;
    end else if (burst) begin
      k = mram_port_pkg::CYC_AUTO_READ;
    end else if (we) begin
      k = mram_port_pkg::CYC_WRITE;
    end else begin
      k = mram_port_pkg::CYC_READ;
    end
    return k;
  endfunction : decode_cycle

  // byte address of a host access; in narrow mode the extra bit picks the lane
  function automatic logic [`MRAM_PTR_W-1:0] byte_addr(
    input logic [`MRAM_ADDR_W-1:0] a, input logic lsb, input logic narrow
  );
    return {a, narrow ? lsb : 1'b0};
  endfunction : byte_addr

  // ------------------------------------------------------------------------
  // cycle detection
  // ------------------------------------------------------------------------
  assign bus_edge = i_ce && i_bus_clk && !bus_clk_reg;
  assign cyc_next = decode_cycle(i_chip_sel_n, i_write_sel, i_burst_step_mode,
                                 i_seq_begin, i_seq_finish, i_carry_in);

  // bus clock history for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bus_clk_reg <= 1'b0;
    end else if (i_ce) begin
      bus_clk_reg <= i_bus_clk;
    end
  end

  // the decoded kind holds until the next bus rising edge
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      mode_reg <= mram_port_pkg::CYC_DISABLE;
    end else if (bus_edge) begin
      mode_reg <= cyc_next;
    end
  end

  // ------------------------------------------------------------------------
  // sensing: a normal read stays quiet until the addressed word is read out; an auto read drives at once
  // ------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sense_cnt_reg <= '0;
      sense_done_reg <= 1'b0;
      read_ptr_reg <= '0;
      read_narrow_reg <= 1'b0;
    end else if (i_ce) begin
      if (bus_edge && (cyc_next == mram_port_pkg::CYC_READ ||
                       cyc_next == mram_port_pkg::CYC_AUTO_READ)) begin
        sense_cnt_reg <= SW'(SENSE_CYC);
        sense_done_reg <= 1'b0;
        read_narrow_reg <= i_byte_width_select;
        read_ptr_reg <= (cyc_next == mram_port_pkg::CYC_AUTO_READ) ? ptr_reg :
                        byte_addr(i_addr, i_addr_lsb, i_byte_width_select);
      end else if (sense_cnt_reg != '0) begin
        sense_cnt_reg <= sense_cnt_reg - 1'b1;
        sense_done_reg <= (sense_cnt_reg == SW'(1));
      end
    end
  end

  // read data captured on the last sensing cycle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dq_reg <= '0;
    end else if (i_ce && sense_cnt_reg == SW'(1)) begin
      if (read_narrow_reg) begin
        dq_reg <= {8'h00, read_ptr_reg[0] ? mem_hi[read_ptr_reg[`MRAM_PTR_W-1:1]] :
                                            mem_lo[read_ptr_reg[`MRAM_PTR_W-1:1]]};
      end else begin
        dq_reg <= {mem_hi[read_ptr_reg[`MRAM_PTR_W-1:1]],
                   mem_lo[read_ptr_reg[`MRAM_PTR_W-1:1]]};
      end
    end
  end
  assign o_dq = dq_reg;

  // output drive decided by cycle kind and the live pin levels
  always_comb begin
    case (mode_reg)
      mram_port_pkg::CYC_READ: begin
        o_dq_oe = i_bus_clk && i_out_drive_en && sense_done_reg;
      end
      mram_port_pkg::CYC_AUTO_READ: begin
        o_dq_oe = !i_chip_sel_n;
      end
      default: begin
        o_dq_oe = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------------
  // auto-increment pointer and carry chain
  // ------------------------------------------------------------------------
  assign ptr_sum = {1'b0, ptr_reg} + (`MRAM_PTR_W+1)'(i_byte_width_select ?
                   `MRAM_STEP_BYTE : `MRAM_STEP_WORD);

  // a normal access seeds the pointer, each auto read steps it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ptr_reg <= '0;
    end else if (bus_edge) begin
      if (cyc_next == mram_port_pkg::CYC_AUTO_READ) begin
        ptr_reg <= ptr_sum[`MRAM_PTR_W-1:0];
      end else if (cyc_next == mram_port_pkg::CYC_READ ||
                   cyc_next == mram_port_pkg::CYC_WRITE) begin
        ptr_reg <= byte_addr(i_addr, i_addr_lsb, i_byte_width_select);
      end
    end
  end

  // carry rises one core cycle after the edge, well inside the allowed delay
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      carry_reg <= 1'b0;
    end else if (bus_edge) begin
      carry_reg <= (cyc_next == mram_port_pkg::CYC_AUTO_READ) && ptr_sum[`MRAM_PTR_W];
    end
  end
  assign o_carry_out = carry_reg;

  // ------------------------------------------------------------------------
  // writes pass through the buffer; draining yields to sensing
  // ------------------------------------------------------------------------
  assign push_valid = bus_edge && (cyc_next == mram_port_pkg::CYC_WRITE);
  assign push_req = '{word_addr: i_addr, lane: i_byte_width_select && i_addr_lsb,
                      narrow: i_byte_width_select, data: i_dq};
  // the array has one port, so a sensing read stalls the drain
  assign pop_ready = (sense_cnt_reg == '0);

  mram_write_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_write_fifo (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_in_valid(push_valid),
    .o_in_ready(o_write_ready),
    .i_in_data(push_req),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_req)
  );

  // array update from the buffer head
  always_ff @(posedge i_mclk) begin
    if (i_ce && pop_valid && pop_ready) begin
      if (!pop_req.narrow || !pop_req.lane) begin
        mem_lo[pop_req.word_addr] <= pop_req.data[7:0];
      end
      if (!pop_req.narrow) begin
        mem_hi[pop_req.word_addr] <= pop_req.data[15:8];
      end else if (pop_req.lane) begin
        mem_hi[pop_req.word_addr] <= pop_req.data[7:0];
      end
    end
  end

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  a_read_decode: assert property (bus_edge && !i_chip_sel_n && !i_write_sel &&
      !i_burst_step_mode |=> mode_reg == mram_port_pkg::CYC_READ)
    else $error("read cycle not decoded");
  a_write_push: assert property (bus_edge && !i_chip_sel_n && i_write_sel &&
      !i_burst_step_mode |-> push_valid ##1 mode_reg == mram_port_pkg::CYC_WRITE)
    else $error("write cycle not buffered");
  a_select_off: assert property (bus_edge && i_chip_sel_n &&
      !i_burst_step_mode |=> mode_reg == mram_port_pkg::CYC_DISABLE && !o_dq_oe)
    else $error("deselected cycle not disabled");
  a_auto_decode: assert property (bus_edge && !i_chip_sel_n && i_burst_step_mode &&
      i_seq_begin && !i_seq_finish && i_carry_in |=> mode_reg == mram_port_pkg::CYC_AUTO_READ)
    else $error("auto read not decoded");
  a_begin_low: assert property (bus_edge && i_burst_step_mode && !i_seq_begin
      |=> mode_reg == mram_port_pkg::CYC_DISABLE)
    else $error("begin low did not disable");
  a_finish_high: assert property (bus_edge && i_burst_step_mode && i_seq_finish
      |=> mode_reg == mram_port_pkg::CYC_DISABLE)
    else $error("finish high did not disable");
  a_carry_in_low: assert property (bus_edge && i_burst_step_mode && !i_carry_in
      |=> mode_reg == mram_port_pkg::CYC_DISABLE)
    else $error("carry input low did not disable");
  a_read_clock_low: assert property (mode_reg == mram_port_pkg::CYC_READ &&
      (!i_bus_clk || !i_out_drive_en) |-> !o_dq_oe)
    else $error("read drove outside clock high and enable");
  a_sense_wait: assert property (bus_edge && cyc_next == mram_port_pkg::CYC_READ
      |=> !o_dq_oe [*8])
    else $error("read drove before sensing ended");
  a_quiet_modes: assert property ((mode_reg == mram_port_pkg::CYC_WRITE ||
      mode_reg == mram_port_pkg::CYC_DISABLE) |-> !o_dq_oe)
    else $error("write or disabled cycle drove data");
  a_auto_drive: assert property (mode_reg == mram_port_pkg::CYC_AUTO_READ
      |-> o_dq_oe == !i_chip_sel_n)
    else $error("auto read drive does not follow select");
  a_ptr_step: assert property (bus_edge && cyc_next == mram_port_pkg::CYC_AUTO_READ &&
      !i_byte_width_select |=> ptr_reg == $past(ptr_reg) + 21'h000002)
    else $error("pointer did not advance by one word");
  a_carry_rise: assert property (bus_edge && cyc_next == mram_port_pkg::CYC_AUTO_READ &&
      ptr_sum[`MRAM_PTR_W] |=> o_carry_out)
    else $error("carry output missed overflow");

  c_read_drive: cover property (mode_reg == mram_port_pkg::CYC_READ && o_dq_oe);
  c_auto_drive: cover property (mode_reg == mram_port_pkg::CYC_AUTO_READ && o_dq_oe);
  c_buffer_full: cover property (!o_write_ready);
  c_carry: cover property (o_carry_out);
endmodule : sync_mram_host_port

// ### verification/host_ctrl_model.sv
// host memory controller model that drives the clocked parallel bus of the port
`include "mram_port_consts.svh"

module host_ctrl_model (
  // core clock
  input wire logic i_mclk,
  // bus controls
  output logic o_bus_clk,
  output logic o_chip_sel_n,
  output logic o_write_sel,
  output logic o_out_drive_en,
  output logic o_burst_step_mode,
  output logic o_seq_begin,
  output logic o_seq_finish,
  output logic o_carry_in,
  output logic o_byte_width_select,
  // address and data
  output logic [`MRAM_ADDR_W-1:0] o_addr,
  output logic o_addr_lsb,
  output logic [`MRAM_DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero: clock low, deselected, drive enable high
  initial begin
    o_bus_clk = 1'b0;
    o_chip_sel_n = 1'b1;
    o_write_sel = 1'b0;
    o_out_drive_en = 1'b1;
    o_burst_step_mode = 1'b0;
    o_seq_begin = 1'b0;
    o_seq_finish = 1'b0;
    o_carry_in = 1'b0;
    o_byte_width_select = 1'b0;
    o_addr = 20'h00000;
    o_addr_lsb = 1'b0;
    o_dq = 16'h0000;
  end

  // controls settle with the bus clock low, then it rises; returns on the taken edge
  task automatic rise(input logic [5:0] ctl, input logic nar, input logic [19:0] a,
                      input logic lsb, input logic [15:0] d);
    @(posedge i_mclk);
    {o_chip_sel_n, o_write_sel, o_burst_step_mode, o_seq_begin, o_seq_finish,
     o_carry_in} <= ctl;
    o_byte_width_select <= nar;
    o_addr <= a;
    o_addr_lsb <= lsb;
    o_dq <= d;
    o_bus_clk <= 1'b0;
    @(posedge i_mclk);
    o_bus_clk <= 1'b1;
    @(posedge i_mclk);
  endtask : rise

  // controls stay put until the clock falls, then idle time keeps the spacing
  task automatic fall(input int idle);
    @(posedge i_mclk);
    o_bus_clk <= 1'b0;
    o_dq <= ~o_dq; // released data must not keep looking valid
    repeat (idle) @(posedge i_mclk);
  endtask : fall

  // select and drive enable may move between bus edges
  task automatic live(input logic cs_n, input logic oe);
    @(posedge i_mclk);
    o_chip_sel_n <= cs_n;
    o_out_drive_en <= oe;
  endtask : live
endmodule : host_ctrl_model

// ### verification/sync_mram_host_port_bench.sv
// self-checking bench for the clocked memory host port
`include "mram_port_consts.svh"

module sync_mram_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // controls, packed as chip select, write, burst, begin, finish, carry in
  // --------------------------------------------------------------------------
  localparam int SENSE = `MRAM_SENSE_CYC;
  localparam logic [5:0] RD = 6'h05;
  localparam logic [5:0] WR = 6'h15;
  localparam logic [5:0] AU = 6'h0D;
  localparam logic [5:0] DIS [4] = '{6'h35, 6'h19, 6'h1F, 6'h1C};

  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic bus_clk, cs_n, we, oe_en, burst, beg, fin, cin, nar, lsb;
  logic [19:0] addr;
  logic [15:0] host_dq, dq;
  logic dq_oe, carry, wready;
  int fails = 0;
  int tests_run = 0;
  int seed = 52821;
  logic [15:0] mem [int];

  // 200 MHz core clock
  always #2.5 mclk = ~mclk;

  sync_mram_host_port dut (
    .i_mclk(mclk), .i_reset(reset), .i_ce(ce), .i_bus_clk(bus_clk),
    .i_chip_sel_n(cs_n), .i_write_sel(we), .i_out_drive_en(oe_en),
    .i_burst_step_mode(burst), .i_seq_begin(beg), .i_seq_finish(fin),
    .i_carry_in(cin), .i_byte_width_select(nar), .i_addr(addr), .i_addr_lsb(lsb),
    .i_dq(host_dq), .o_dq(dq), .o_dq_oe(dq_oe), .o_carry_out(carry),
    .o_write_ready(wready)
  );

  host_ctrl_model host (
    .i_mclk(mclk), .o_bus_clk(bus_clk), .o_chip_sel_n(cs_n), .o_write_sel(we),
    .o_out_drive_en(oe_en), .o_burst_step_mode(burst), .o_seq_begin(beg),
    .o_seq_finish(fin), .o_carry_in(cin), .o_byte_width_select(nar),
    .o_addr(addr), .o_addr_lsb(lsb), .o_dq(host_dq)
  );

  // --------------------------------------------------------------------------
  // shared checks and bus cycles
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      fails++;
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // write cycle; the expected image follows the byte lanes that a narrow write touches
  task automatic wr(input logic [19:0] a, input logic l, input logic n, input logic [15:0] d);
    host.rise(WR, n, a, l, d);
    #1 check("write drive", 16'h0000, 16'(dq_oe));
    host.fall(2);
    if (!n) mem[a] = d;
    else if (l) mem[a][15:8] = d[7:0];
    else mem[a][7:0] = d[7:0];
  endtask : wr

  // read cycle; the first look waits one edge so the old mode has gone
  task automatic rd(input logic [19:0] a, input logic l, input logic n, output logic [15:0] v);
    host.rise(RD, n, a, l, 16'($random(seed)));
    @(posedge mclk);
    #1 check("drive during sensing", 16'h0000, 16'(dq_oe));
    repeat (SENSE) @(posedge mclk);
    #1 check("read drive", 16'h0001, 16'(dq_oe));
    v = dq;
    host.live(1'b0, 1'b0);
    #1 check("drive with enable low", 16'h0000, 16'(dq_oe));
    host.live(1'b0, 1'b1);
    host.fall(16);
    #1 check("drive with bus clock low", 16'h0000, 16'(dq_oe));
  endtask : rd

  // auto read; the address lines carry zero, so only the inner pointer can be used
  task automatic au(input logic n, input logic exp_carry, output logic [15:0] v);
    host.rise(AU, n, 20'h00000, 1'b0, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 check("carry out", 16'(exp_carry), 16'(carry));
    check("auto drive", 16'h0001, 16'(dq_oe));
    host.fall(0);
    host.live(1'b0, 1'b0);
    #1 check("auto drive, clock and enable low", 16'h0001, 16'(dq_oe));
    host.live(1'b1, 1'b1);
    #1 check("auto drive deselected", 16'h0000, 16'(dq_oe));
    host.live(1'b0, 1'b1);
    repeat (SENSE) @(posedge mclk);
    #1 v = dq;
    repeat (12) @(posedge mclk);
  endtask : au

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    logic [15:0] v, v1, v2;
    logic [19:0] a;
    int k;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    #1 check("reset drive", 16'h0000, 16'(dq_oe));
    check("reset carry", 16'h0000, 16'(carry));
    check("reset ready", 16'h0001, 16'(wready));
    $display("test reset done");
    // random words written back to back, then read back
    a = 20'($random(seed)) & 20'h7FFF0;
    for (k = 0; k < 6; k++) wr(a + 20'(k), 1'b0, 1'b0, 16'($random(seed)));
    for (k = 0; k < 6; k++) begin
      rd(a + 20'(k), 1'b0, 1'b0, v);
      check("read word", mem[a + 20'(k)], v);
    end
    $display("test write and read done");
    // the pointer is seeded by a read; each auto read takes the word under it, then steps
    rd(a, 1'b0, 1'b0, v);
    au(1'b0, 1'b0, v);
    au(1'b0, 1'b0, v1);
    au(1'b0, 1'b0, v2);
    check("auto first", mem[a], v);
    check("auto second", mem[a + 20'h00001], v1);
    check("auto third", mem[a + 20'h00002], v2);
    $display("test auto read done");
    // every disable case with write asserted must neither drive nor write
    for (k = 0; k < 4; k++) begin
      wr(a, 1'b0, 1'b0, 16'h5A5A ^ 16'(k));
      host.rise(DIS[k], 1'b0, a, 1'b0, 16'hFFFF);
      repeat (SENSE + 2) @(posedge mclk);
      #1 check("disabled drive", 16'h0000, 16'(dq_oe));
      host.fall(16);
      rd(a, 1'b0, 1'b0, v);
      check("disabled write kept out", mem[a], v);
    end
    // with the clock enable low a whole write cycle must go by unseen
    @(posedge mclk);
    ce <= 1'b0;
    host.rise(WR, 1'b0, a, 1'b0, 16'hFFFF);
    host.fall(2);
    ce <= 1'b1;
    rd(a, 1'b0, 1'b0, v);
    check("frozen write kept out", mem[a], v);
    $display("test disable done");
    // byte lanes; the upper data byte of a narrow write must be ignored
    a = 20'($random(seed)) | 20'h80000;
    v1 = 16'($random(seed));
    wr(a, 1'b0, 1'b1, {8'hFF, v1[7:0]});
    wr(a, 1'b1, 1'b1, {8'hFF, v1[15:8]});
    rd(a, 1'b0, 1'b1, v);
    check("narrow low byte", {8'h00, v1[7:0]}, v);
    au(1'b1, 1'b0, v);
    check("auto narrow low", {8'h00, v1[7:0]}, v);
    au(1'b1, 1'b0, v);
    check("auto narrow high", {8'h00, v1[15:8]}, v);
    rd(a, 1'b1, 1'b1, v);
    check("narrow high byte", {8'h00, v1[15:8]}, v);
    rd(a, 1'b0, 1'b0, v);
    check("wide after narrow", v1, v);
    $display("test byte width done");
    // top word: the first auto step overflows the pointer
    wr(20'hFFFFF, 1'b0, 1'b0, 16'h1234);
    rd(20'hFFFFF, 1'b0, 1'b0, v);
    au(1'b0, 1'b1, v);
    check("carry word", 16'h1234, v);
    $display("test carry done");
    // reads restart sensing so the buffer cannot drain; the 33rd write is dropped
    a = 20'h01000;
    wr(a + 20'h00020, 1'b0, 1'b0, 16'hC3C3);
    for (k = 0; k < 33; k++) begin
      host.rise(RD, 1'b0, 20'h00000, 1'b0, 16'h0000);
      host.fall(0);
      host.rise(WR, 1'b0, a + 20'(k), 1'b0, 16'(k) ^ 16'hA000);
      host.fall(0);
      if (k < 32) mem[a + 20'(k)] = 16'(k) ^ 16'hA000;
      if (k == 31) #1 check("ready when full", 16'h0000, 16'(wready));
    end
    k = 0;
    while (wready !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    if (k == 200) begin
      $display("unexpected write ready: expected 1, seen %b", wready);
      fails++;
      give_verdict();
    end
    // a full buffer drains one entry every cycle once sensing stops, so this margin covers it
    repeat (64) @(posedge mclk);
    for (k = 30; k < 33; k++) begin
      rd(a + 20'(k), 1'b0, 1'b0, v);
      check("buffered word", mem[a + 20'(k)], v);
    end
    $display("test buffer fill done");
    give_verdict();
  end
endmodule : sync_mram_host_port_bench
